/* File: rtl/vims_arb.sv */
// Priority resolver over the sixteen maskable sources
`timescale 1ns/10ps
`include "vims_consts.svh"
module vims_arb (
  vims_arb_if.arb a
);
  import vims_pkg::*;
  logic [4:0] best [0:16];
  logic [1:0] blvl [0:16];
  assign best[0] = `VIMS_NO_WINNER;
  assign blvl[0] = `VIMS_LVL_LOWEST;
  genvar g;
  generate
    for (g = 0; g < `VIMS_NUM_SRC; g = g + 1) begin : g_stage
      wire [1:0] my_lvl = a.lvl[2*g+1:2*g];
      // Strictly better level only, so equal levels keep the lower index
      wire take = a.pend[g] && (best[g][4] || (my_lvl < blvl[g]));
      assign best[g+1] = take ? 5'(g) : best[g];
      assign blvl[g+1] = take ? my_lvl : blvl[g];
    end
  endgenerate
  assign a.hit = !best[16][4];
  assign a.idx = best[16][3:0];
endmodule

/* File: rtl/vims_arb_if.sv */
// Carrier between the top and the priority resolver
`timescale 1ns/10ps
interface vims_arb_if;
  logic [15:0] pend;
  logic [31:0] lvl;
  logic hit;
  logic [3:0] idx;
  modport top (output pend, output lvl, input hit, input idx);
  modport arb (input pend, input lvl, output hit, output idx);
endinterface

/* File: rtl/vims_consts.svh */
// Constants of the vectored interrupt macro service block
`ifndef VIMS_CONSTS_SVH
`define VIMS_CONSTS_SVH
`define VIMS_NUM_SRC 16
`define VIMS_VEC_RESET 16'h0000
`define VIMS_VEC_NMI 16'h0002
`define VIMS_VEC_WDT 16'h0004
`define VIMS_VEC_MASK_BASE 16'h0006
`define VIMS_VEC_TRAP 16'h003c
`define VIMS_VEC_BRK 16'h003e
`define VIMS_VEC_NONE 16'h0000
`define VIMS_LVL_LOWEST 2'h3
`define VIMS_CNT_ZERO 8'h00
`define VIMS_CNT_ONE 8'h01
`define VIMS_BANK_RESET 3'h0
`define VIMS_SRC_RESET 4'h0
`define VIMS_WORD_RESET 16'h0000
`define VIMS_SRC_CONV 4'hf
`define VIMS_NO_WINNER 5'h10
`endif

/* File: rtl/vims_ctrl.sv */
// Overview of operation
// - Four software levels for maskable requests
// - Vectored, macro service or context switch
// - Sixteen vectors 0006H to 0024H, shared entries
// - Lower default index wins simultaneous requests of equal level
// - NMI 0002H, watchdog 0004H, vectored only
// - Watchdog overflow drives active-low pin low
// - Trap 003CH, break 003EH, reset 0000H
// - Five macro service modes selectable
// - Counter mode steps 8-bit counter silently
// - Counter zero raises vectored request
// - Conversion done may start macro service
// - Bank from the source's three-bit bank select field, or from BREAK_BANK_I for a bank switch break
// - Switch saves PC, status; loads bank vector
`timescale 1ns/10ps
`include "vims_consts.svh"
module vims_ctrl (
  input wire logic CORE_CLK_I,
  input wire logic SRST_I,
  input wire logic NMI_PIN_I,
  input wire logic WATCHDOG_OVERFLOW_REQUEST_I,
  input wire logic [15:0] MASKABLE_REQUEST_I,
  input wire logic EXT_PIN0_REQUEST_I,
  input wire logic CAPCMP30_MATCH_REQUEST_I,
  input wire logic EXT_PIN3_REQUEST_I,
  input wire logic CAPCMP20_MATCH_REQUEST_I,
  input wire logic [15:0] ENABLE_I,
  input wire logic [31:0] LEVEL_I,
  input wire logic [15:0] MACRO_ENABLE_I,
  input wire logic [15:0] CTXSW_ENABLE_I,
  input wire logic [47:0] MACRO_MODE_I,
  input wire logic [15:0] COUNT_UP_I,
  input wire logic [15:0] COUNTER_LOAD_I,
  input wire logic [7:0] COUNTER_LOAD_VALUE_I,
  input wire logic [47:0] BANK_SELECT_I,
  input wire logic [15:0] BANK_VECTOR_I,
  input wire logic [15:0] CURRENT_PC_I,
  input wire logic [15:0] CURRENT_STATUS_WORD_I,
  input wire logic TRAP_I,
  input wire logic SOFTWARE_BREAK_I,
  input wire logic BANK_SWITCH_BREAK_I,
  input wire logic [2:0] BREAK_BANK_I,
  input wire logic ACK_I,
  output logic IRQ_O,
  output vims_pkg::vims_kind_t KIND_O,
  output vims_pkg::vims_handling_t HANDLING_O,
  output logic [15:0] VECTOR_O,
  output logic [3:0] SOURCE_O,
  output logic [2:0] BANK_O,
  output logic [15:0] SAVED_PC_O,
  output logic [15:0] SAVED_STATUS_WORD_O,
  output logic [15:0] NEW_PC_O,
  output logic MACRO_DONE_O,
  output vims_pkg::vims_msmode_t MACRO_MODE_O,
  output logic [3:0] MACRO_SOURCE_O,
  output logic CONVERSION_MOVE_O,
  output logic WATCHDOG_OUT_N_O
);
  import vims_pkg::*;
  function automatic logic [15:0] mask_vector(input logic [3:0] i);
    mask_vector = `VIMS_VEC_MASK_BASE + {11'h000, i, 1'b0};
  endfunction
  logic nmi_s1_reg, nmi_s2_reg, nmi_s3_reg;
  logic [15:0] pend_reg, pend_next;
  logic [7:0] service_counter_reg [0:15];
  logic wdt_out_reg;
  vims_state_t state_reg;
  logic irq_reg, macro_done_reg, conv_move_reg;
  vims_kind_t kind_reg;
  vims_handling_t hand_reg;
  vims_msmode_t msmode_reg;
  logic [15:0] vec_reg, spc_reg, sst_reg, npc_reg;
  logic [3:0] src_reg, msrc_reg;
  logic [2:0] bank_reg;
  vims_arb_if arb_bus();
  vims_arb u_arb (.a(arb_bus));
  // Shared sources are merged into one entry
  wire [15:0] raw_req = MASKABLE_REQUEST_I |
    {11'h000, EXT_PIN3_REQUEST_I | CAPCMP20_MATCH_REQUEST_I, 2'b00,
     EXT_PIN0_REQUEST_I | CAPCMP30_MATCH_REQUEST_I, 1'b0};
  wire nmi_edge = nmi_s2_reg && !nmi_s3_reg;
  wire nmi_wdt = nmi_edge || WATCHDOG_OVERFLOW_REQUEST_I;
  wire sw_take = TRAP_I || SOFTWARE_BREAK_I || BANK_SWITCH_BREAK_I;
  assign arb_bus.pend = pend_reg & ENABLE_I;
  assign arb_bus.lvl = LEVEL_I;
  wire [3:0] win = arb_bus.idx;
  wire idle = (state_reg == VIMS_ST_IDLE);
  wire [2:0] win_mode = MACRO_MODE_I[3*win +: 3];
  wire [7:0] win_cnt = service_counter_reg[win];
  wire [7:0] cnt_step = COUNT_UP_I[win] ? win_cnt + `VIMS_CNT_ONE : win_cnt - `VIMS_CNT_ONE;
  // Counter mode reaching zero falls through to a vectored request
  wire macro_zero = (win_mode == VIMS_MS_COUNTER) && (cnt_step == `VIMS_CNT_ZERO);
  // A zero step waits while a trap or break is taken, else its vectored request would be lost
  wire macro_take = idle && arb_bus.hit && MACRO_ENABLE_I[win] && !nmi_wdt && !(macro_zero && sw_take);
  wire macro_silent = macro_take && !macro_zero;
  // Macro-enabled winners whose service ends at zero leave the macro path and vector
  wire vec_take_mask = idle && arb_bus.hit && !macro_silent && !nmi_wdt && !sw_take;
  always_comb begin
    pend_next = pend_reg | raw_req;
    if (vec_take_mask || macro_take) begin
      pend_next[win] = raw_req[win];
    end
  end
  always_ff @(posedge CORE_CLK_I) begin
    if (SRST_I) begin
      nmi_s1_reg <= 1'b0;
      nmi_s2_reg <= 1'b0;
      nmi_s3_reg <= 1'b0;
      pend_reg <= `VIMS_WORD_RESET;
      wdt_out_reg <= 1'b1;
    end else begin
      nmi_s1_reg <= NMI_PIN_I;
      nmi_s2_reg <= nmi_s1_reg;
      nmi_s3_reg <= nmi_s2_reg;
      pend_reg <= pend_next;
      // Pin stays low until reset, so it can hold the system reset line
      if (WATCHDOG_OVERFLOW_REQUEST_I) begin
        wdt_out_reg <= 1'b0;
      end
    end
  end
  genvar g;
  generate
    for (g = 0; g < `VIMS_NUM_SRC; g = g + 1) begin : g_cnt
      always_ff @(posedge CORE_CLK_I) begin
        if (SRST_I) begin
          service_counter_reg[g] <= `VIMS_CNT_ZERO;
        end else if (COUNTER_LOAD_I[g]) begin
          service_counter_reg[g] <= COUNTER_LOAD_VALUE_I;
        end else if (macro_take && win == g && win_mode == VIMS_MS_COUNTER) begin
          service_counter_reg[g] <= cnt_step;
        end
      end
    end
  endgenerate
  always_ff @(posedge CORE_CLK_I) begin
    if (SRST_I) begin
      macro_done_reg <= 1'b0;
      conv_move_reg <= 1'b0;
      msmode_reg <= VIMS_MS_COUNTER;
      msrc_reg <= `VIMS_SRC_RESET;
    end else begin
      macro_done_reg <= macro_silent;
      // Conversion done in a transfer mode hands the data move to hardware
      conv_move_reg <= macro_silent && (win == `VIMS_SRC_CONV) && (win_mode != VIMS_MS_COUNTER);
      if (macro_silent) begin
        msmode_reg <= vims_msmode_t'(win_mode);
        msrc_reg <= win;
      end
    end
  end
  always_ff @(posedge CORE_CLK_I) begin
    if (SRST_I) begin
      state_reg <= VIMS_ST_IDLE;
      irq_reg <= 1'b0;
      kind_reg <= VIMS_K_NONE;
      hand_reg <= VIMS_H_VECTOR;
      vec_reg <= `VIMS_VEC_RESET;
      src_reg <= `VIMS_SRC_RESET;
      bank_reg <= `VIMS_BANK_RESET;
      spc_reg <= `VIMS_WORD_RESET;
      sst_reg <= `VIMS_WORD_RESET;
      npc_reg <= `VIMS_WORD_RESET;
    end else if (!idle) begin
      if (ACK_I) begin
        state_reg <= VIMS_ST_IDLE;
        irq_reg <= 1'b0;
      end
    end else if (nmi_edge) begin
      state_reg <= VIMS_ST_ACK;
      irq_reg <= 1'b1;
      kind_reg <= VIMS_K_NMI;
      hand_reg <= VIMS_H_VECTOR;
      vec_reg <= `VIMS_VEC_NMI;
    end else if (WATCHDOG_OVERFLOW_REQUEST_I) begin
      state_reg <= VIMS_ST_ACK;
      irq_reg <= 1'b1;
      kind_reg <= VIMS_K_WDT;
      hand_reg <= VIMS_H_VECTOR;
      vec_reg <= `VIMS_VEC_WDT;
    end else if (TRAP_I) begin
      state_reg <= VIMS_ST_ACK;
      irq_reg <= 1'b1;
      kind_reg <= VIMS_K_TRAP;
      hand_reg <= VIMS_H_VECTOR;
      vec_reg <= `VIMS_VEC_TRAP;
    end else if (SOFTWARE_BREAK_I) begin
      state_reg <= VIMS_ST_ACK;
      irq_reg <= 1'b1;
      kind_reg <= VIMS_K_BRK;
      hand_reg <= VIMS_H_VECTOR;
      vec_reg <= `VIMS_VEC_BRK;
    end else if (BANK_SWITCH_BREAK_I) begin
      state_reg <= VIMS_ST_ACK;
      irq_reg <= 1'b1;
      kind_reg <= VIMS_K_BANK_SWITCH_BREAK;
      hand_reg <= VIMS_H_CTXSW;
      vec_reg <= `VIMS_VEC_NONE;
      bank_reg <= BREAK_BANK_I;
      spc_reg <= CURRENT_PC_I;
      sst_reg <= CURRENT_STATUS_WORD_I;
      npc_reg <= BANK_VECTOR_I;
    end else if (vec_take_mask) begin
      state_reg <= VIMS_ST_ACK;
      irq_reg <= 1'b1;
      kind_reg <= VIMS_K_MASKABLE;
      vec_reg <= mask_vector(win);
      src_reg <= win;
      if (CTXSW_ENABLE_I[win] && !MACRO_ENABLE_I[win]) begin
        hand_reg <= VIMS_H_CTXSW;
        bank_reg <= BANK_SELECT_I[3*win +: 3];
        spc_reg <= CURRENT_PC_I;
        sst_reg <= CURRENT_STATUS_WORD_I;
        npc_reg <= BANK_VECTOR_I;
      end else begin
        hand_reg <= VIMS_H_VECTOR;
      end
    end
  end
  assign IRQ_O = irq_reg;
  assign KIND_O = kind_reg;
  assign HANDLING_O = hand_reg;
  assign VECTOR_O = vec_reg;
  assign SOURCE_O = src_reg;
  assign BANK_O = bank_reg;
  assign SAVED_PC_O = spc_reg;
  assign SAVED_STATUS_WORD_O = sst_reg;
  assign NEW_PC_O = npc_reg;
  assign MACRO_DONE_O = macro_done_reg;
  assign MACRO_MODE_O = msmode_reg;
  assign MACRO_SOURCE_O = msrc_reg;
  assign CONVERSION_MOVE_O = conv_move_reg;
  assign WATCHDOG_OUT_N_O = wdt_out_reg;
endmodule

/* File: rtl/vims_pkg.sv */
// Types of the vectored interrupt macro service block
package vims_pkg;
  typedef enum logic [1:0] {
    VIMS_H_VECTOR = 2'b00,
    VIMS_H_MACRO = 2'b01,
    VIMS_H_CTXSW = 2'b10
  } vims_handling_t;
  typedef enum logic [2:0] {
    VIMS_MS_COUNTER = 3'b000,
    VIMS_MS_BLOCK = 3'b001,
    VIMS_MS_BLOCK_PTR = 3'b010,
    VIMS_MS_DIFF = 3'b011,
    VIMS_MS_DIFF_PTR = 3'b100
  } vims_msmode_t;
  typedef enum logic [2:0] {
    VIMS_K_NONE = 3'b000,
    VIMS_K_MASKABLE = 3'b001,
    VIMS_K_NMI = 3'b010,
    VIMS_K_WDT = 3'b011,
    VIMS_K_TRAP = 3'b100,
    VIMS_K_BRK = 3'b101,
    VIMS_K_BANK_SWITCH_BREAK = 3'b110
  } vims_kind_t;
  typedef enum logic [1:0] {
    VIMS_ST_IDLE = 2'b00,
    VIMS_ST_ACK = 2'b01
  } vims_state_t;
endpackage

/* File: testbench/vims_core_model.sv */
// Behavioural CPU core that acknowledges presented interrupts
`timescale 1ns/10ps
module vims_core_model (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic irq_i,
  input wire logic [3:0] delay_i,
  output logic ack_o
);
  logic [3:0] wait_reg;
  // One-cycle ack, then the wait count restarts from zero while the request is high
  always_ff @(posedge clk_i) begin
    if (srst_i || ack_o) begin
      ack_o <= 1'b0;
      wait_reg <= 4'h0;
    end else if (irq_i) begin
      ack_o <= (wait_reg >= delay_i);
      wait_reg <= wait_reg + 4'h1;
    end
  end
endmodule

/* File: testbench/vims_ctrl_properties.sv */
// Port-level checker for the interrupt controller
`timescale 1ns/10ps
module vims_ctrl_properties (
  input logic CORE_CLK_I,
  input logic SRST_I,
  input logic ACK_I,
  input logic WATCHDOG_OVERFLOW_REQUEST_I,
  input logic IRQ_O,
  input vims_pkg::vims_kind_t KIND_O,
  input vims_pkg::vims_handling_t HANDLING_O,
  input logic [15:0] VECTOR_O,
  input logic [3:0] SOURCE_O,
  input logic CONVERSION_MOVE_O,
  input logic [3:0] MACRO_SOURCE_O,
  input logic WATCHDOG_OUT_N_O
);
  import vims_pkg::*;
  default clocking @(posedge CORE_CLK_I); endclocking
  default disable iff (SRST_I);
  irq_hold_a: assert property (IRQ_O && !ACK_I |=> IRQ_O) else $error("irq dropped without ack");
  ack_drop_a: assert property (IRQ_O && ACK_I |=> !IRQ_O) else $error("irq kept after ack");
  wdt_pin_a: assert property (WATCHDOG_OVERFLOW_REQUEST_I |-> ##[1:2] !WATCHDOG_OUT_N_O)
    else $error("pin not low");
  wdt_sticky_a: assert property (!WATCHDOG_OUT_N_O |=> !WATCHDOG_OUT_N_O) else $error("pin released");
  nmi_vec_a: assert property (IRQ_O && KIND_O == VIMS_K_NMI |-> VECTOR_O == 16'h0002
    && HANDLING_O == VIMS_H_VECTOR) else $error("nmi vector wrong");
  wdt_vec_a: assert property (IRQ_O && KIND_O == VIMS_K_WDT |-> VECTOR_O == 16'h0004
    && HANDLING_O == VIMS_H_VECTOR) else $error("watchdog vector wrong");
  mask_vec_a: assert property (IRQ_O && KIND_O == VIMS_K_MASKABLE && HANDLING_O != VIMS_H_CTXSW
    |-> VECTOR_O == 16'h0006 + {11'h000, SOURCE_O, 1'b0}) else $error("maskable vector wrong");
  trap_vec_a: assert property (IRQ_O && KIND_O == VIMS_K_TRAP |-> VECTOR_O == 16'h003c)
    else $error("trap vector");
  brk_vec_a: assert property (IRQ_O && KIND_O == VIMS_K_BRK |-> VECTOR_O == 16'h003e)
    else $error("break vector");
  conv_move_a: assert property (CONVERSION_MOVE_O |-> MACRO_SOURCE_O == 4'hf) else $error("move source");
  reset_idle_a: assert property (disable iff (1'b0) SRST_I |=> !IRQ_O && WATCHDOG_OUT_N_O)
    else $error("not idle after reset");
  cover property ($rose(IRQ_O));
  cover property (CONVERSION_MOVE_O);
  cover property ($fell(WATCHDOG_OUT_N_O));
  cover property (IRQ_O && HANDLING_O == VIMS_H_CTXSW);
endmodule

/* File: testbench/vims_ctrl_tb.sv */
// Self-checking bench of the interrupt controller
`timescale 1ns/10ps
module vims_ctrl_tb;
  import vims_pkg::*;
  logic CORE_CLK_I = 1'b0, SRST_I = 1'b1, NMI_PIN_I = 1'b0, WATCHDOG_OVERFLOW_REQUEST_I = 1'b0;
  logic EXT_PIN0_REQUEST_I = 1'b0, CAPCMP30_MATCH_REQUEST_I = 1'b0, EXT_PIN3_REQUEST_I = 1'b0;
  logic CAPCMP20_MATCH_REQUEST_I = 1'b0, TRAP_I = 1'b0, SOFTWARE_BREAK_I = 1'b0, BANK_SWITCH_BREAK_I = 1'b0;
  logic [15:0] MASKABLE_REQUEST_I = 16'h0, ENABLE_I = 16'hffff, MACRO_ENABLE_I = 16'h0, CTXSW_ENABLE_I = 16'h0;
  logic [15:0] COUNT_UP_I = 16'h0, COUNTER_LOAD_I = 16'h0, BANK_VECTOR_I = 16'h0abc, CURRENT_PC_I = 16'h1234;
  logic [15:0] CURRENT_STATUS_WORD_I = 16'h00a5, VECTOR_O, SAVED_PC_O, SAVED_STATUS_WORD_O, NEW_PC_O;
  logic [31:0] LEVEL_I = 32'hffffffff;
  logic [47:0] MACRO_MODE_I = 48'h0, BANK_SELECT_I = 48'h0;
  logic [7:0] COUNTER_LOAD_VALUE_I = 8'h00;
  logic [2:0] BREAK_BANK_I = 3'h6, BANK_O;
  logic [3:0] ack_delay = 4'h1, SOURCE_O, MACRO_SOURCE_O;
  logic ACK_I, IRQ_O, MACRO_DONE_O, CONVERSION_MOVE_O, WATCHDOG_OUT_N_O;
  vims_kind_t KIND_O;
  vims_handling_t HANDLING_O;
  vims_msmode_t MACRO_MODE_O;
  int n_errors = 0, tests_run = 0;
  logic [15:0] rq [6] = '{16'h0001, 16'h0008, 16'h8000, 16'h0030, 16'hc000, 16'h0402};
  logic [15:0] v1 [6] = '{16'h0006, 16'h000c, 16'h0024, 16'h000e, 16'h0022, 16'h0008};
  logic [15:0] v2 [6] = '{16'h0000, 16'h0000, 16'h0000, 16'h0010, 16'h0024, 16'h001a};
  always #25 CORE_CLK_I = ~CORE_CLK_I;
  vims_ctrl dut (
    .CORE_CLK_I(CORE_CLK_I), .SRST_I(SRST_I), .NMI_PIN_I(NMI_PIN_I),
    .WATCHDOG_OVERFLOW_REQUEST_I(WATCHDOG_OVERFLOW_REQUEST_I), .MASKABLE_REQUEST_I(MASKABLE_REQUEST_I),
    .EXT_PIN0_REQUEST_I(EXT_PIN0_REQUEST_I), .CAPCMP30_MATCH_REQUEST_I(CAPCMP30_MATCH_REQUEST_I),
    .EXT_PIN3_REQUEST_I(EXT_PIN3_REQUEST_I), .CAPCMP20_MATCH_REQUEST_I(CAPCMP20_MATCH_REQUEST_I),
    .ENABLE_I(ENABLE_I), .LEVEL_I(LEVEL_I), .MACRO_ENABLE_I(MACRO_ENABLE_I), .CTXSW_ENABLE_I(CTXSW_ENABLE_I),
    .MACRO_MODE_I(MACRO_MODE_I), .COUNT_UP_I(COUNT_UP_I), .COUNTER_LOAD_I(COUNTER_LOAD_I),
    .COUNTER_LOAD_VALUE_I(COUNTER_LOAD_VALUE_I), .BANK_SELECT_I(BANK_SELECT_I), .BANK_VECTOR_I(BANK_VECTOR_I),
    .CURRENT_PC_I(CURRENT_PC_I), .CURRENT_STATUS_WORD_I(CURRENT_STATUS_WORD_I), .TRAP_I(TRAP_I),
    .SOFTWARE_BREAK_I(SOFTWARE_BREAK_I), .BANK_SWITCH_BREAK_I(BANK_SWITCH_BREAK_I), .BREAK_BANK_I(BREAK_BANK_I),
    .ACK_I(ACK_I), .IRQ_O(IRQ_O), .KIND_O(KIND_O), .HANDLING_O(HANDLING_O), .VECTOR_O(VECTOR_O),
    .SOURCE_O(SOURCE_O), .BANK_O(BANK_O), .SAVED_PC_O(SAVED_PC_O), .SAVED_STATUS_WORD_O(SAVED_STATUS_WORD_O),
    .NEW_PC_O(NEW_PC_O), .MACRO_DONE_O(MACRO_DONE_O), .MACRO_MODE_O(MACRO_MODE_O),
    .MACRO_SOURCE_O(MACRO_SOURCE_O), .CONVERSION_MOVE_O(CONVERSION_MOVE_O), .WATCHDOG_OUT_N_O(WATCHDOG_OUT_N_O)
  );
  vims_core_model core (.clk_i(CORE_CLK_I), .srst_i(SRST_I), .irq_i(IRQ_O), .delay_i(ack_delay), .ack_o(ACK_I));
  task end_sim;
    $display("checks %0d errors %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task chk(string what, logic [15:0] exp, logic [15:0] got);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Selector: 0 irq, 1 macro done, 2 conversion move
  task wait_for(int sel);
    logic seen;
    seen = 1'b0;
    for (int i = 0; i < 30 && !seen; i++) begin
      @(posedge CORE_CLK_I);
      #1;
      seen = sel == 0 ? IRQ_O === 1'b1 : sel == 1 ? MACRO_DONE_O === 1'b1 : CONVERSION_MOVE_O === 1'b1;
    end
    if (!seen) begin
      n_errors++;
      $display("BAD wait %0d expected 1 seen 0", sel);
      end_sim;
    end
  endtask
  task drop;
    for (int i = 0; i < 30 && IRQ_O !== 1'b0; i++) begin
      @(posedge CORE_CLK_I);
      #1;
    end
    // A request that never drops is a hang, so it ends the run as a mismatch
    if (IRQ_O !== 1'b0) begin
      n_errors++;
      $display("BAD irq drop expected 0 seen %b", IRQ_O);
      end_sim;
    end
  endtask
  task req(logic [15:0] b);
    @(posedge CORE_CLK_I) MASKABLE_REQUEST_I <= b;
    @(posedge CORE_CLK_I) MASKABLE_REQUEST_I <= 16'h0;
  endtask
  task exp_irq(vims_kind_t k, logic [15:0] v);
    wait_for(0);
    chk("kind", 16'(k), 16'(KIND_O));
    chk("vector", v, VECTOR_O);
    drop;
  endtask
  task ctx(logic [2:0] bank);
    wait_for(0);
    chk("handling", 16'(VIMS_H_CTXSW), 16'(HANDLING_O));
    chk("bank", 16'(bank), 16'(BANK_O));
    chk("saved pc", 16'h1234, SAVED_PC_O);
    chk("saved status", 16'h00a5, SAVED_STATUS_WORD_O);
    chk("new pc", 16'h0abc, NEW_PC_O);
    drop;
  endtask
  initial begin
    repeat (10) @(posedge CORE_CLK_I);
    SRST_I <= 1'b0;
    #1;
    chk("irq", 16'h0, 16'(IRQ_O));
    chk("vector", 16'h0000, VECTOR_O);
    for (int r = 0; r < 6; r++) begin
      req(rq[r]);
      exp_irq(VIMS_K_MASKABLE, v1[r]);
      chk("source", (v1[r] - 16'h6) >> 1, 16'(SOURCE_O));
      if (v2[r] != 16'h0) exp_irq(VIMS_K_MASKABLE, v2[r]);
    end
    @(posedge CORE_CLK_I) LEVEL_I <= 32'h3ffffff6;
    ack_delay <= 4'h6;
    req(16'h8003);
    exp_irq(VIMS_K_MASKABLE, 16'h0024);
    exp_irq(VIMS_K_MASKABLE, 16'h0008);
    exp_irq(VIMS_K_MASKABLE, 16'h0006);
    @(posedge CORE_CLK_I) LEVEL_I <= 32'hffffffff;
    for (int s = 0; s < 4; s++) begin
      @(posedge CORE_CLK_I)
        {CAPCMP20_MATCH_REQUEST_I, EXT_PIN3_REQUEST_I, CAPCMP30_MATCH_REQUEST_I, EXT_PIN0_REQUEST_I} <= 4'h1 << s;
      @(posedge CORE_CLK_I)
        {CAPCMP20_MATCH_REQUEST_I, EXT_PIN3_REQUEST_I, CAPCMP30_MATCH_REQUEST_I, EXT_PIN0_REQUEST_I} <= 4'h0;
      exp_irq(VIMS_K_MASKABLE, s < 2 ? 16'h0008 : 16'h000e);
    end
    @(posedge CORE_CLK_I) NMI_PIN_I <= 1'b1;
    exp_irq(VIMS_K_NMI, 16'h0002);
    @(posedge CORE_CLK_I) NMI_PIN_I <= 1'b0;
    @(posedge CORE_CLK_I) TRAP_I <= 1'b1;
    @(posedge CORE_CLK_I) TRAP_I <= 1'b0;
    exp_irq(VIMS_K_TRAP, 16'h003c);
    @(posedge CORE_CLK_I) SOFTWARE_BREAK_I <= 1'b1;
    @(posedge CORE_CLK_I) SOFTWARE_BREAK_I <= 1'b0;
    exp_irq(VIMS_K_BRK, 16'h003e);
    @(posedge CORE_CLK_I) BANK_SWITCH_BREAK_I <= 1'b1;
    @(posedge CORE_CLK_I) BANK_SWITCH_BREAK_I <= 1'b0;
    ctx(3'h6);
    @(posedge CORE_CLK_I) CTXSW_ENABLE_I <= 16'h0004;
    BANK_SELECT_I <= 48'h140;
    req(16'h0004);
    ctx(3'h5);
    @(posedge CORE_CLK_I) MACRO_ENABLE_I <= 16'h8040;
    COUNTER_LOAD_I <= 16'h0040;
    COUNTER_LOAD_VALUE_I <= 8'h02;
    @(posedge CORE_CLK_I) COUNTER_LOAD_I <= 16'h0;
    req(16'h0040);
    wait_for(1);
    chk("macro source", 16'h6, 16'(MACRO_SOURCE_O));
    chk("irq", 16'h0, 16'(IRQ_O));
    req(16'h0040);
    exp_irq(VIMS_K_MASKABLE, 16'h0012);
    @(posedge CORE_CLK_I) COUNT_UP_I <= 16'h0040;
    COUNTER_LOAD_I <= 16'h0040;
    COUNTER_LOAD_VALUE_I <= 8'hff;
    @(posedge CORE_CLK_I) COUNTER_LOAD_I <= 16'h0;
    req(16'h0040);
    exp_irq(VIMS_K_MASKABLE, 16'h0012);
    for (int m = 1; m < 5; m++) begin
      @(posedge CORE_CLK_I) MACRO_MODE_I[47:45] <= 3'(m);
      req(16'h8000);
      wait_for(2);
      chk("macro mode", 16'(m), 16'(MACRO_MODE_O));
    end
    @(posedge CORE_CLK_I) WATCHDOG_OVERFLOW_REQUEST_I <= 1'b1;
    @(posedge CORE_CLK_I) WATCHDOG_OVERFLOW_REQUEST_I <= 1'b0;
    exp_irq(VIMS_K_WDT, 16'h0004);
    chk("watchdog pin", 16'h0, 16'(WATCHDOG_OUT_N_O));
    @(posedge CORE_CLK_I) SRST_I <= 1'b1;
    repeat (3) @(posedge CORE_CLK_I);
    SRST_I <= 1'b0;
    #1;
    chk("watchdog pin", 16'h1, 16'(WATCHDOG_OUT_N_O));
    end_sim;
  end
endmodule
bind vims_ctrl vims_ctrl_properties chk (
  .CORE_CLK_I(CORE_CLK_I), .SRST_I(SRST_I), .ACK_I(ACK_I),
  .WATCHDOG_OVERFLOW_REQUEST_I(WATCHDOG_OVERFLOW_REQUEST_I), .IRQ_O(IRQ_O), .KIND_O(KIND_O),
  .HANDLING_O(HANDLING_O), .VECTOR_O(VECTOR_O), .SOURCE_O(SOURCE_O), .CONVERSION_MOVE_O(CONVERSION_MOVE_O),
  .MACRO_SOURCE_O(MACRO_SOURCE_O), .WATCHDOG_OUT_N_O(WATCHDOG_OUT_N_O)
);
